// ==== hdl/agc_fifo.sv ====
// Synchronous FIFO holding gain-adjusted I/Q pairs
`timescale 1ns/10ps
module agc_fifo #(
  parameter int WIDTH = 30,
  parameter int DEPTH = agc_pkg::FIFO_DEPTH
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  stream_if.snk     wr,
  stream_if.src     rd
);
  localparam int PW = $clog2(DEPTH);

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
  begin : g_bad
    $error("agc_fifo: DEPTH must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0]   cnt;
  } fifo_type;

  fifo_type         s_r;
  fifo_type         s_nxt;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  // ****************************************************************
  // Handshakes
  // ****************************************************************
  // Full and empty come straight from the count, so no slot is wasted
  assign wr.ready = (s_r.cnt != (PW+1)'(DEPTH));
  assign rd.valid = (s_r.cnt != '0);
  assign rd.data  = mem[s_r.rp];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb
  begin
    s_nxt = s_r;
    if (push)
    begin
      s_nxt.wp = s_r.wp + 1'b1;
    end
    if (pop)
    begin
      s_nxt.rp = s_r.rp + 1'b1;
    end
    if (push && !pop)
    begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
    else if (pop && !push)
    begin
      s_nxt.cnt = s_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // Storage has no reset; contents are only read behind valid
  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      mem[s_r.wp] <= wr.data;
    end
  end
endmodule

// ==== hdl/agc_loop_gain_filter.sv ====
// Gain control loop: error detector, loop gain, limited integrator
`timescale 1ns/10ps
// Behaviour
// - Disable bit 31 forces detector error to zero; otherwise error passes
// - Fraction code is 4-bit unsigned, value code times 0.0625
// - Shift code E of 3 bits gives factor 2^-(6+E)
// - Error is attenuated by fraction/16 times shift factor before filter
// - Fraction and shift codes sit in parameter bits 24 to 30
// - Filter accumulates scaled error; result drives I and Q multipliers
// - Accumulator bounded by upper/lower limits on its top eight bits
// - Upper and lower limit words occupy parameter bits 0 to 15
// - Limit and gain words: 6-bit mantissa, 2-bit exponent 1,2,4,8
// - Multipliers apply (1 + mantissa/64) times 2^exponent to I and Q
// - Scaled error into the accumulator is eleven bits wide
// - Error is magnitude minus 8-bit threshold from bits 16 to 23
// - Top eight accumulator bits are readable as the gain level
module agc_loop_gain_filter #(
  parameter int DEPTH = agc_pkg::FIFO_DEPTH
) (
  input  wire logic                              ref_clk,
  input  wire logic                              reset_n,
  input  wire logic [agc_pkg::PARAM_W-1:0]       loop_param,
  input  wire logic [agc_pkg::MAG_W-1:0]         mag_in,
  input  wire logic                              mag_valid,
  input  wire logic signed [agc_pkg::IQ_W-1:0]   i_in,
  input  wire logic signed [agc_pkg::IQ_W-1:0]   q_in,
  input  wire logic                              iq_valid,
  output logic                                   iq_ready,
  output logic signed [agc_pkg::OUT_W-1:0]       i_out,
  output logic signed [agc_pkg::OUT_W-1:0]       q_out,
  output logic                                   out_valid,
  input  wire logic                              out_ready,
  output logic [agc_pkg::WORD_W-1:0]             agc_level
);
  localparam int ACC_W = agc_pkg::ACC_W;
  localparam int FR    = agc_pkg::ACC_FRAC;
  localparam int OW    = agc_pkg::OUT_W;

  if (DEPTH < 2)
  begin : g_bad
    $error("agc_loop_gain_filter: DEPTH too small");
  end

  typedef struct packed {
    agc_pkg::state_type          st;
    logic [ACC_W-1:0]            acc;
    logic [agc_pkg::WORD_W-1:0]  gain;
  } regs_type;

  regs_type                               s_r;
  regs_type                               s_nxt;
  logic                                   rst_meta_r;
  logic                                   rst_n_r;
  logic                                   dis;
  logic [agc_pkg::FRAC_CODE_W-1:0]        loop_gain_fraction_code;
  logic [agc_pkg::SHIFT_CODE_W-1:0]       loop_gain_shift_code;
  logic [agc_pkg::WORD_W-1:0]             thr;
  logic [agc_pkg::WORD_W-1:0]             up_lim;
  logic [agc_pkg::WORD_W-1:0]             lo_lim;
  logic signed [agc_pkg::MAG_W:0]         err;
  logic signed [13:0]                     prod;
  logic signed [agc_pkg::ERR_W-1:0]       sc_err;
  logic signed [ACC_W+1:0]                sum;

  // ****************************************************************
  // Reset release
  // ****************************************************************
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // ****************************************************************
  // Parameter fields
  // ****************************************************************
  assign dis = loop_param[agc_pkg::DISABLE_BIT];
  assign loop_gain_fraction_code =
    loop_param[agc_pkg::FRAC_CODE_LSB +: agc_pkg::FRAC_CODE_W];
  assign loop_gain_shift_code =
    loop_param[agc_pkg::SHIFT_CODE_LSB +: agc_pkg::SHIFT_CODE_W];
  assign thr    = loop_param[agc_pkg::THRESH_LSB +: agc_pkg::WORD_W];
  assign up_lim = loop_param[agc_pkg::UPPER_LSB +: agc_pkg::WORD_W];
  assign lo_lim = loop_param[agc_pkg::LOWER_LSB +: agc_pkg::WORD_W];

  // ****************************************************************
  // Error detector and loop gain
  // ****************************************************************
  // Magnitude minus threshold, or zero while the loop is disabled
  assign err = dis ? '0
             : $signed({1'b0, mag_in}) - $signed({1'b0, thr});
  // Fraction is code/16; the extra shift of two plus the 8 fraction
  // bits of the accumulator give the 2^-6 base weight
  assign prod = err * $signed({1'b0, loop_gain_fraction_code});
  assign sc_err = agc_pkg::ERR_W'(prod >>>
    ({2'b00, loop_gain_shift_code} + 5'(agc_pkg::BASE_SHIFT)));
  assign sum = $signed({2'b00, s_r.acc})
             + $signed({{(ACC_W+2-agc_pkg::ERR_W){sc_err[agc_pkg::ERR_W-1]}},
                        sc_err});

  // ****************************************************************
  // Limited integrator
  // ****************************************************************
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.gain = s_r.acc[ACC_W-1 -: agc_pkg::WORD_W];
    unique case (s_r.st)
      agc_pkg::ST_INIT:
      begin
        // Limits are only seen after reset release, so load here
        s_nxt.acc = {lo_lim, {FR{1'b0}}};
        s_nxt.st  = agc_pkg::ST_TRACK;
      end
      agc_pkg::ST_TRACK:
      begin
        if (mag_valid)
        begin
          // Compare on the top eight bits; clamp rather than wrap
          if (sum < 0 || sum[ACC_W+1:ACC_W] != 2'b00)
          begin
            s_nxt.acc = sum[ACC_W+1] ? {lo_lim, {FR{1'b0}}}
                                     : {up_lim, {FR{1'b0}}};
          end
          else if (sum[ACC_W-1 -: agc_pkg::WORD_W] > up_lim)
          begin
            s_nxt.acc = {up_lim, {FR{1'b0}}};
          end
          else if (sum[ACC_W-1 -: agc_pkg::WORD_W] < lo_lim)
          begin
            s_nxt.acc = {lo_lim, {FR{1'b0}}};
          end
          else
          begin
            s_nxt.acc = sum[ACC_W-1:0];
          end
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      s_r <= '{st: agc_pkg::ST_INIT, acc: '0, gain: '0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign agc_level = s_r.gain;

  // ****************************************************************
  // Gain adjusters and output buffer
  // ****************************************************************
  // (1 + m/64) * 2^e, result keeps 6 fraction bits dropped
  function automatic logic signed [OW-1:0] gain_apply
  (
    input logic signed [agc_pkg::IQ_W-1:0] x,
    input logic [agc_pkg::WORD_W-1:0]      w
  );
    logic signed [20:0] p;
    p = 21'(x * $signed({2'b01, w[agc_pkg::MANT_W-1:0]}));
    p = p <<< w[agc_pkg::WORD_W-1 -: agc_pkg::EXP_W];
    return p[OW+agc_pkg::MANT_W-1:agc_pkg::MANT_W];
  endfunction

  stream_if #(.WIDTH(2*OW)) wr_s ();
  stream_if #(.WIDTH(2*OW)) rd_s ();

  // Back-pressure from the sink reaches the I/Q source through here
  assign wr_s.valid = iq_valid;
  assign wr_s.data  = {gain_apply(i_in, s_r.gain),
                       gain_apply(q_in, s_r.gain)};
  assign iq_ready   = wr_s.ready;
  assign out_valid  = rd_s.valid;
  assign i_out      = rd_s.data[2*OW-1:OW];
  assign q_out      = rd_s.data[OW-1:0];
  assign rd_s.ready = out_ready;

  agc_fifo #(
    .WIDTH (2*OW),
    .DEPTH (DEPTH)
  ) u_fifo (
    .ref_clk (ref_clk),
    .rst_n   (rst_n_r),
    .wr      (wr_s),
    .rd      (rd_s)
  );

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n_r);

  property p_disable_zero;
    dis |-> (err == 0 && sc_err == 0);
  endproperty
  a_disable_zero: assert property (p_disable_zero)
    else $error("error not zero while loop disabled");

  property p_zero_fraction;
    loop_gain_fraction_code == 4'h0 |-> sc_err == 0;
  endproperty
  a_zero_fraction: assert property (p_zero_fraction)
    else $error("zero fraction code still scales error");

  property p_max_shift;
    loop_gain_shift_code == 3'h7 |-> (sc_err <= 7 && sc_err >= -8);
  endproperty
  a_max_shift: assert property (p_max_shift)
    else $error("largest shift code leaves error too large");

  property p_sign_kept;
    (!dis && mag_in > thr && loop_gain_fraction_code != 0)
      |-> sc_err >= 0;
  endproperty
  a_sign_kept: assert property (p_sign_kept)
    else $error("positive error scaled negative");

  property p_in_limits;
    (s_r.st == agc_pkg::ST_TRACK && mag_valid && lo_lim <= up_lim)
      ##1 $stable(loop_param)
      |-> (s_r.acc[ACC_W-1 -: 8] <= up_lim
           && s_r.acc[ACC_W-1 -: 8] >= lo_lim);
  endproperty
  a_in_limits: assert property (p_in_limits)
    else $error("accumulator left the programmed limits");

  property p_sat_hold;
    (s_r.st == agc_pkg::ST_TRACK && mag_valid && sc_err >= 0
     && s_r.acc[ACC_W-1 -: 8] == up_lim && lo_lim <= up_lim)
      ##1 $stable(loop_param)
      |-> s_r.acc[ACC_W-1 -: 8] == up_lim;
  endproperty
  a_sat_hold: assert property (p_sat_hold)
    else $error("accumulator wrapped past upper limit");

  property p_level_follows;
    ##1 agc_level == $past(s_r.acc[ACC_W-1 -: 8]);
  endproperty
  a_level_follows: assert property (p_level_follows)
    else $error("gain level does not follow accumulator");

  // The state cannot move on the release edge itself, so the sampled
  // copy of the internal reset gates the check
  property p_init_lower;
    rst_n_r && s_r.st == agc_pkg::ST_INIT
      |=> (s_r.acc == {$past(lo_lim), 8'h00}
           && s_r.st == agc_pkg::ST_TRACK);
  endproperty
  a_init_lower: assert property (p_init_lower)
    else $error("accumulator not started at lower limit");

  property p_unity_gain;
    (iq_valid && s_r.gain == 8'h00)
      |-> wr_s.data[2*OW-1:OW] == OW'(i_in);
  endproperty
  a_unity_gain: assert property (p_unity_gain)
    else $error("zero gain word does not pass I unchanged");

  c_track_up: cover property (mag_valid && sc_err > 0 ##1 mag_valid);
  c_hit_upper: cover property (mag_valid && s_r.acc[ACC_W-1 -: 8] == up_lim);
  c_fifo_full: cover property (iq_valid && !iq_ready);
endmodule

// ==== hdl/agc_pkg.sv ====
// Constants and types shared by the gain loop and its output buffer
package agc_pkg;
  // ****************************************************************
  // Loop parameter word layout
  // ****************************************************************
  localparam int DISABLE_BIT   = 31;
  localparam int FRAC_CODE_LSB = 27;
  localparam int FRAC_CODE_W   = 4;
  localparam int SHIFT_CODE_LSB = 24;
  localparam int SHIFT_CODE_W  = 3;
  localparam int THRESH_LSB    = 16;
  localparam int UPPER_LSB     = 8;
  localparam int LOWER_LSB     = 0;
  localparam int PARAM_W       = 32;

  // ****************************************************************
  // Widths and formats
  // ****************************************************************
  localparam int MAG_W      = 8;
  localparam int WORD_W     = 8;
  localparam int MANT_W     = 6;
  localparam int EXP_W      = 2;
  localparam int ERR_W      = 11;
  localparam int ACC_FRAC   = 8;
  localparam int ACC_W      = WORD_W + ACC_FRAC;
  localparam int BASE_SHIFT = 2;
  localparam int IQ_W       = 10;
  localparam int OUT_W      = 15;
  localparam int FIFO_DEPTH = 32;

  // ****************************************************************
  // Loop sequencing
  // ****************************************************************
  typedef enum logic [1:0]
  {
    ST_INIT  = 2'b01,
    ST_TRACK = 2'b10
  } state_type;
endpackage

// ==== hdl/stream_if.sv ====
// Valid/ready stream carrier between the loop core and its buffer
`timescale 1ns/10ps
interface stream_if #(parameter int WIDTH = 8) ();
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;

  modport src
  (
    output data,
    output valid,
    input  ready
  );
  modport snk
  (
    input  data,
    input  valid,
    output ready
  );
endinterface

// ==== test/iq_sink.sv ====
// Model of the sink that takes the gain-adjusted I/Q stream
`timescale 1ns/10ps
module iq_sink (
  input  wire logic                             ref_clk,
  input  wire logic                             stall,
  input  wire logic                             slow,
  input  wire logic                             out_valid,
  input  wire logic signed [agc_pkg::OUT_W-1:0] i_out,
  input  wire logic signed [agc_pkg::OUT_W-1:0] q_out,
  output logic                                  out_ready
);
  logic        tick_r;
  logic [29:0] got[$];

  initial tick_r = 1'b0;

  // Slow mode takes every other word, so the buffer sees back pressure
  assign out_ready = !stall && (!slow || tick_r);

  always @(posedge ref_clk)
  begin
    tick_r <= !tick_r;
    if (out_valid && out_ready)
      got.push_back({i_out, q_out});
  end
endmodule

// ==== test/testbench.sv ====
// Self-checking bench for the gain control loop and its buffer
`timescale 1ns/10ps
`define CHECK(g, e) \
  begin \
    tests_run++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("FAIL t=%0t got %h exp %h", $time, g, e); \
    end \
  end
module testbench;
  typedef struct packed
  {
    logic [31:0] param;
    logic [7:0]  mag;
    logic [7:0]  level;
  } row_type;

  logic                          ref_clk;
  logic                          reset_n;
  logic [31:0]                   loop_param;
  logic [7:0]                    mag_in;
  logic                          mag_valid;
  logic signed [9:0]             i_in;
  logic signed [9:0]             q_in;
  logic                          iq_valid;
  logic                          iq_ready;
  logic signed [14:0]            i_out;
  logic signed [14:0]            q_out;
  logic                          out_valid;
  logic                          out_ready;
  logic [7:0]                    agc_level;
  logic [29:0]                   exp_w;
  logic                          stall;
  logic                          slow;
  int                            num_errors;
  int                            tests_run;
  int                            cycles;
  int                            n;

  // ****************************************************************
  // Ordinary cases: one loop update each, level after the update
  // ****************************************************************
  // Accumulator value is carried from row to row, so order matters
  row_type rows [15] = '{
    '{32'h7840_C010, 8'hff, 8'h12},
    '{32'h7840_C010, 8'hff, 8'h15},
    '{32'hF840_C010, 8'hff, 8'h15},
    '{32'h7840_C010, 8'h00, 8'h14},
    '{32'h7F40_C010, 8'hff, 8'h14},
    '{32'h0840_C010, 8'hff, 8'h14},
    '{32'h7840_C010, 8'hff, 8'h17},
    '{32'h78FF_C010, 8'hff, 8'h17},
    '{32'h7840_1810, 8'hff, 8'h18},
    '{32'h7840_1810, 8'hff, 8'h18},
    '{32'h7840_1817, 8'h00, 8'h17},
    '{32'h7840_1817, 8'h00, 8'h17},
    '{32'h7840_3030, 8'hff, 8'h30},
    '{32'h7840_3030, 8'h00, 8'h30},
    '{32'h7840_C5C5, 8'h00, 8'hC5}
  };

  agc_loop_gain_filter i_dut (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .loop_param (loop_param),
    .mag_in     (mag_in),
    .mag_valid  (mag_valid),
    .i_in       (i_in),
    .q_in       (q_in),
    .iq_valid   (iq_valid),
    .iq_ready   (iq_ready),
    .i_out      (i_out),
    .q_out      (q_out),
    .out_valid  (out_valid),
    .out_ready  (out_ready),
    .agc_level  (agc_level)
  );

  iq_sink i_sink (
    .ref_clk   (ref_clk),
    .stall     (stall),
    .slow      (slow),
    .out_valid (out_valid),
    .i_out     (i_out),
    .q_out     (q_out),
    .out_ready (out_ready)
  );

  always #2 ref_clk = ~ref_clk;

  // Gain word applied to a sample: (64 + m) / 64 times 2^e
  function automatic logic [14:0] gain_ref(input int x, input logic [7:0] w);
    logic signed [20:0] p;
    p = 21'(x * (64 + int'(w[5:0])));
    p = p <<< w[7:6];
    return p[20:6];
  endfunction

  task automatic do_reset(input logic [31:0] p);
    @(posedge ref_clk);
    loop_param <= p;
    reset_n    <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask

  task automatic update(input logic [31:0] p, input logic [7:0] m);
    @(posedge ref_clk);
    loop_param <= p;
    mag_in     <= m;
    mag_valid  <= 1'b1;
    @(posedge ref_clk);
    mag_valid <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // A hang counts as a mismatch and still reaches the verdict
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      num_errors++;
      conclude();
    end
  end

  initial
  begin
    ref_clk = 1'b0;
    reset_n = 1'b0;
    loop_param = '0;
    mag_in = '0;
    mag_valid = 1'b0;
    i_in = '0;
    q_in = '0;
    iq_valid = 1'b0;
    stall = 1'b1;
    slow = 1'b0;
    num_errors = 0;
    tests_run = 0;
    cycles = 0;
    do_reset(32'h7840_C010);
    `CHECK(agc_level, 8'h10)
    `CHECK(iq_ready, 1'b1)
    $display("test reset done");
    foreach (rows[k])
    begin
      update(rows[k].param, rows[k].mag);
      `CHECK(agc_level, rows[k].level)
    end
    $display("test loop rows done");
    // ****************************************************************
    // Fill the buffer with the sink stalled, then drain it slowly
    // ****************************************************************
    for (int k = 0; k < 32; k++)
    begin
      @(posedge ref_clk);
      iq_valid <= 1'b1;
      i_in     <= 10'(k * 31 - 500);
      q_in     <= 10'(400 - k * 27);
    end
    @(posedge ref_clk);
    i_in <= 10'sh005;
    @(posedge ref_clk);
    #1;
    `CHECK(iq_ready, 1'b0)
    // The refused sample stays offered until a slot frees up
    @(posedge ref_clk);
    stall <= 1'b0;
    slow  <= 1'b1;
    #1;
    while (!iq_ready)
    begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    iq_valid <= 1'b0;
    n = 0;
    while (i_sink.got.size() < 33 && n < 200)
    begin
      @(posedge ref_clk);
      n++;
    end
    repeat (5) @(posedge ref_clk);
    #1;
    `CHECK(i_sink.got.size(), 33)
    `CHECK(out_valid, 1'b0)
    for (int k = 0; k < 32 && k < i_sink.got.size(); k++)
    begin
      exp_w = {gain_ref(k * 31 - 500, 8'hC5),
               gain_ref(400 - k * 27, 8'hC5)};
      `CHECK(i_sink.got[k], exp_w)
    end
    exp_w = {gain_ref(5, 8'hC5), gain_ref(400 - 31 * 27, 8'hC5)};
    `CHECK(i_sink.got[32], exp_w)
    $display("test buffer done");
    do_reset(32'h7840_C022);
    `CHECK(agc_level, 8'h22)
    `CHECK(out_valid, 1'b0)
    $display("test second reset done");
    // ****************************************************************
    // A zero gain word after reset passes samples through unscaled
    // ****************************************************************
    do_reset(32'h7840_0000);
    `CHECK(agc_level, 8'h00)
    @(posedge ref_clk);
    iq_valid <= 1'b1;
    i_in     <= 10'h3fd;
    q_in     <= 10'h007;
    @(posedge ref_clk);
    iq_valid <= 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    `CHECK(i_sink.got.size(), 34)
    `CHECK(i_sink.got[33], {15'h7ffd, 15'h0007})
    $display("test unity gain done");
    conclude();
  end
endmodule
